// ### verilog/aes_seq_regs.svh
`ifndef AES_SEQ_REGS_SVH
`define AES_SEQ_REGS_SVH

// register word indices on the avalon bus
`define REG_CTRL        3'h0
`define REG_STATUS      3'h1
`define REG_BLOCK_COUNT 3'h2
`define REG_KEY_IN      3'h3
`define REG_DATA_IN     3'h4
`define REG_DATA_OUT    3'h5
`define REG_XOR_IN      3'h6
`define REG_XOR_DATA_IN 3'h7

// control register fields
`define CTRL_OP_LSB     4'h0
`define CTRL_CM_LSB     4'h2
`define CTRL_DMA_EN     4'h4
`define CTRL_SOFT_RST   4'h7
`define CTRL_KEY_WR     4'h8

// reset values and counts
`define CTRL_RESET      5'h00
`define BLOCK_RESET     8'h00
`define BLOCK_BYTES     5'h10
`define ROUND_CYCLES    4'ha

`endif

// ### verilog/aes_seq_pkg.sv
package aes_seq_pkg;

    typedef enum logic [1:0] {
        OP_ENC     = 2'b00,
        OP_DEC     = 2'b01,
        OP_KEY_GEN = 2'b10,
        OP_DEC_PRE = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        CM_ECB = 2'b00,
        CM_CBC = 2'b01,
        CM_OFB = 2'b10,
        CM_CFB = 2'b11
    } cm_t;

    typedef enum logic [2:0] {PH_IDLE, PH_BUSY, PH_T0, PH_T1, PH_T2} phase_t;

    typedef enum logic [2:0] {TG_NONE, TG_DIN, TG_XIN, TG_XDIN, TG_DOUT} tgt_t;

    typedef struct packed {
        logic        dma_en;
        cm_t         cm;
        op_t         op;
    } ctrl_t;

    typedef struct packed {
        logic [2:0]  address;
        logic        read;
        logic        write;
        logic [15:0] writedata;
        logic [1:0]  byteenable;
    } av_req_t;

endpackage

// ### verilog/aes_cipher_mode_dma_sequencer.sv
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "aes_seq_regs.svh"

// What this block does
// [RULE1] cfb encrypt: line 0 feeds xor input
// [RULE2] cfb: line 1 then drains data output
// [RULE3] cfb decrypt: line 0 feeds xor input
// [RULE4] cfb decrypt: line 2 then loads data input
// [RULE5] re-raise until 16 bytes, byte or word
// [RULE6] dma enable low means no requests
// [RULE7] shadow key restored for every block
// [RULE8] software leaves key alone once started
// [RULE9] nonzero block count starts the sequence
// [RULE10] dma counts are multiples of 8 or 16
// [RULE11] dma uses static priorities, level triggers
// [RULE12] ecb blocks processed independently
// [RULE13] ecb encrypt: line 0 reads, line 1 writes
// [RULE14] ecb decrypt: line 0 reads, line 1 writes
// [RULE15] decrypt key generated first, then reused
// [RULE16] cbc chains previous ciphertext by xor
// [RULE17] cbc encrypt: iv loaded before first block
// [RULE18] cbc encrypt: xor-data write starts encryption
// [RULE19] xor input write only xors, never starts
// [RULE20] soft reset clears internal state
// [RULE21] cbc decrypt uses three lines
// [RULE22] cbc decrypt line 0 first carries iv
// [RULE23] operation select encoding
// [RULE24] word transfers pulse eight times per block
// [RULE25] key-written flag validates held key
// [RULE26] cipher mode select encoding
// [RULE27] count blocks down, stop after last
// [RULE28] request drops on accept, re-raises if more
module aes_cipher_mode_dma_sequencer (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire aes_seq_pkg::av_req_t i_av,
    output logic [15:0]               o_readdata,
    output logic                      o_waitrequest,
    output logic [2:0]                o_dma_trigger,
    output logic                      o_busy
);
    import aes_seq_pkg::*;

    function automatic tgt_t tgt_of(input cm_t cm, input op_t op, input logic [1:0] line);
        logic dec;
        dec = (op != OP_ENC);
        tgt_of = TG_NONE;
        unique case (cm) // RULE26
            CM_ECB: tgt_of = (line == 2'd0) ? TG_DOUT : (line == 2'd1) ? TG_DIN : TG_NONE;
            CM_CBC: if (!dec)
                    tgt_of = (line == 2'd0) ? TG_DOUT : (line == 2'd1) ? TG_XDIN : TG_NONE;
                else
                    tgt_of = (line == 2'd0) ? TG_XIN : (line == 2'd1) ? TG_DOUT : TG_DIN;
            CM_OFB: tgt_of = (line == 2'd0) ? TG_XIN : (line == 2'd1) ? TG_DOUT : TG_XDIN;
            CM_CFB: tgt_of = (line == 2'd0) ? TG_XIN : (line == 2'd1) ? TG_DOUT
                           : (dec ? TG_DIN : TG_NONE); // RULE1 RULE4
        endcase
    endfunction

    function automatic logic [127:0] put_bytes(input logic [127:0] s, input logic [3:0] idx,
                                               input logic [15:0] d, input logic two,
                                               input logic do_xor);
        logic [127:0] r;
        logic [3:0]   idx1;
        r = s;
        idx1 = idx + 4'h1;
        r[idx*8 +: 8] = do_xor ? (s[idx*8 +: 8] ^ d[7:0]) : d[7:0];
        if (two)
            r[idx1*8 +: 8] = do_xor ? (s[idx1*8 +: 8] ^ d[15:8]) : d[15:8];
        return r;
    endfunction

    ctrl_t        ctrl_reg;
    logic [7:0]   blk_reg;
    logic [127:0] state_reg;
    logic [127:0] state_next;
    logic [127:0] key_reg;
    logic [127:0] key_shadow_reg;
    logic [127:0] rkey_reg;
    logic [4:0]   key_cnt_reg;
    logic [4:0]   xfer_cnt_reg;
    phase_t       phase_reg;
    phase_t       phase_next;
    logic         seq_reg;
    logic         served_reg;
    logic [3:0]   round_reg;
    logic         key_written_reg;
    logic         ready_reg;
    logic         rd_done_reg;
    logic [15:0]  readdata_reg;

    // bus decode
    wire        two_bytes  = &i_av.byteenable;
    wire        any_byte   = |i_av.byteenable;
    wire [7:0]  lane_lo    = i_av.byteenable[0] ? i_av.writedata[7:0] : i_av.writedata[15:8];
    wire [15:0] wr_bytes   = {i_av.writedata[15:8], lane_lo};
    wire        wr_acc     = i_av.write && any_byte;
    wire        rd_acc     = i_av.read && rd_done_reg && any_byte;
    wire        ctrl_wr    = wr_acc && i_av.address == `REG_CTRL;
    wire        blk_wr     = wr_acc && i_av.address == `REG_BLOCK_COUNT;
    wire        key_wr     = wr_acc && i_av.address == `REG_KEY_IN;
    wire        soft_rst   = ctrl_wr && i_av.writedata[`CTRL_SOFT_RST];
    wire [4:0]  step       = two_bytes ? 5'h02 : 5'h01;

    wire tgt_t  acc_tgt    = (wr_acc && i_av.address == `REG_DATA_IN)     ? TG_DIN
                           : (wr_acc && i_av.address == `REG_XOR_IN)      ? TG_XIN
                           : (wr_acc && i_av.address == `REG_XOR_DATA_IN) ? TG_XDIN
                           : (rd_acc && i_av.address == `REG_DATA_OUT)    ? TG_DOUT
                           : TG_NONE;

    wire        in_t       = phase_reg == PH_T0 || phase_reg == PH_T1 || phase_reg == PH_T2;
    wire [1:0]  line       = (phase_reg == PH_T2) ? 2'd2 : (phase_reg == PH_T1) ? 2'd1 : 2'd0;
    wire tgt_t  line_tgt   = tgt_of(ctrl_reg.cm, ctrl_reg.op, line);
    wire tgt_t  next_tgt   = tgt_of(ctrl_reg.cm, ctrl_reg.op, line + 2'd1);
    wire tgt_t  first_tgt  = tgt_of(ctrl_reg.cm, ctrl_reg.op, 2'd0);

    // during a line phase a data access counts only toward the register the active line serves; when idle, any data access counts
    wire        hit        = in_t && acc_tgt != TG_NONE && acc_tgt == line_tgt;
    wire        idle_acc   = phase_reg == PH_IDLE && !seq_reg && acc_tgt != TG_NONE;
    wire        cnt_en     = (hit || idle_acc) && !soft_rst;
    wire [4:0]  cnt_sum    = xfer_cnt_reg + step;
    wire        last_hit   = cnt_en && cnt_sum >= `BLOCK_BYTES; // RULE5 RULE24
    wire        cipher_done = phase_reg == PH_BUSY && round_reg == 4'h1;
    wire        seq_start  = blk_wr && i_av.writedata[7:0] != 8'h00 && ctrl_reg.dma_en;
    wire        start_ciph = phase_next == PH_BUSY && phase_reg != PH_BUSY;
    wire        key_last   = key_wr && key_cnt_reg + step >= `BLOCK_BYTES;

    // line outputs
    wire [2:0]  line_onehot = (phase_reg == PH_T2) ? 3'b100
                            : (phase_reg == PH_T1) ? 3'b010 : 3'b001;
    assign o_dma_trigger = (ctrl_reg.dma_en && in_t && !served_reg) ? line_onehot
                                                                     : 3'b000; // RULE6 RULE28
    assign o_busy        = phase_reg == PH_BUSY;
    assign o_waitrequest = i_av.read && !rd_done_reg;
    assign o_readdata    = readdata_reg;

    // read mux
    wire [3:0]  rd_idx     = xfer_cnt_reg[3:0];
    wire [7:0]  dout_lo    = state_reg[rd_idx*8 +: 8];
    wire [7:0]  dout_hi    = two_bytes ? state_reg[(rd_idx + 4'h1)*8 +: 8] : dout_lo;
    wire [15:0] status_w   = {9'h000, seq_reg, ready_reg, key_written_reg, o_busy, o_dma_trigger};
    wire [15:0] rd_mux     = (i_av.address == `REG_CTRL)        ? {11'h000, ctrl_reg}
                           : (i_av.address == `REG_STATUS)      ? status_w
                           : (i_av.address == `REG_BLOCK_COUNT) ? {8'h00, blk_reg}
                           : (i_av.address == `REG_DATA_OUT)    ? {dout_hi, dout_lo}
                           : 16'h0000;

    // sequencing of the three lines
    always_comb
    begin
        phase_next = phase_reg;
        if (soft_rst)
            phase_next = PH_IDLE;
        else if (seq_start && phase_reg == PH_IDLE) // RULE9
            phase_next = (first_tgt == TG_DOUT) ? PH_T1 // RULE13 RULE14 RULE18
                       : (ctrl_reg.cm == CM_CBC) ? PH_T2 : PH_BUSY; // RULE21
        else if (cipher_done)
            phase_next = seq_reg ? PH_T0 : PH_IDLE; // RULE1 RULE3
        else if (last_hit && in_t)
        begin
            if (line_tgt == TG_DOUT && blk_reg == 8'h00)
                phase_next = PH_IDLE; // RULE27
            else if (line != 2'd2 && next_tgt != TG_NONE)
                phase_next = (line == 2'd0) ? PH_T1 : PH_T2; // RULE2 RULE4
            else
                phase_next = PH_BUSY; // RULE18
        end
        else if (last_hit && (acc_tgt == TG_DIN || acc_tgt == TG_XDIN))
            phase_next = PH_BUSY;
    end

    // xin only xors; din replaces; xdin xors then starts
    assign state_next = soft_rst ? 128'h0 // RULE20
                      : (phase_reg == PH_BUSY)
                        ? ({state_reg[119:0], state_reg[127:120]} ^ rkey_reg)
                      : (cnt_en && acc_tgt != TG_DOUT)
                        ? put_bytes(state_reg, xfer_cnt_reg[3:0], wr_bytes, two_bytes,
                                    acc_tgt != TG_DIN) // RULE16 RULE19
                      : state_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            phase_reg    <= PH_IDLE;
            state_reg    <= 128'h0;
            xfer_cnt_reg <= 5'h00;
            served_reg   <= 1'b0;
            round_reg    <= 4'h0;
        end
        else
        begin
            phase_reg    <= phase_next;
            state_reg    <= state_next;
            served_reg   <= cnt_en; // RULE28
            round_reg    <= start_ciph ? `ROUND_CYCLES
                          : (phase_reg == PH_BUSY) ? round_reg - 4'h1 : round_reg;
            xfer_cnt_reg <= (soft_rst || last_hit || phase_next != phase_reg) ? 5'h00
                          : cnt_en ? cnt_sum : xfer_cnt_reg;
        end
    end

    // round key always starts from the shadow copy
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            rkey_reg <= 128'h0;
        else if (start_ciph)
            rkey_reg <= key_shadow_reg; // RULE7 RULE12
        else if (phase_reg == PH_BUSY)
            rkey_reg <= {rkey_reg[126:0], rkey_reg[127]};
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            key_reg        <= 128'h0;
            key_shadow_reg <= 128'h0;
            key_cnt_reg    <= 5'h00;
        end
        else if (key_wr)
        begin
            key_reg     <= put_bytes(key_reg, key_cnt_reg[3:0], wr_bytes, two_bytes, 1'b0);
            key_cnt_reg <= key_last ? 5'h00 : key_cnt_reg + step;
            if (key_last)
                key_shadow_reg <= put_bytes(key_reg, key_cnt_reg[3:0], wr_bytes, two_bytes,
                                            1'b0);
        end
    end

    wire op_change = ctrl_wr && i_av.writedata[1:0] != ctrl_reg.op;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            ctrl_reg        <= `CTRL_RESET;
            key_written_reg <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_reg <= i_av.writedata[4:0]; // RULE23 RULE26
            if (key_last || (ctrl_wr && i_av.writedata[`CTRL_KEY_WR]))
                key_written_reg <= 1'b1; // RULE25 RULE15
            else if (op_change)
                key_written_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            blk_reg   <= `BLOCK_RESET;
            seq_reg   <= 1'b0;
            ready_reg <= 1'b0;
        end
        else
        begin
            if (blk_wr)
                blk_reg <= i_av.writedata[7:0];
            else if (cipher_done && seq_reg && blk_reg != 8'h00)
                blk_reg <= blk_reg - 8'h01; // RULE27
            if (soft_rst || (seq_reg && phase_next == PH_IDLE))
                seq_reg <= 1'b0;
            else if (seq_start && phase_reg == PH_IDLE)
                seq_reg <= 1'b1; // RULE9
            if (cipher_done)
                ready_reg <= 1'b1;
            else if (soft_rst || key_wr || acc_tgt == TG_DOUT || acc_tgt == TG_DIN)
                ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            rd_done_reg  <= 1'b0;
            readdata_reg <= 16'h0000;
        end
        else
        begin
            rd_done_reg <= i_av.read && !rd_done_reg;
            if (i_av.read && !rd_done_reg)
                readdata_reg <= rd_mux;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_dis_quiet;
        !ctrl_reg.dma_en |-> o_dma_trigger == 3'b000;
    endproperty
    a_dis_quiet: assert property (p_dis_quiet) else $error("request with dma off"); // RULE6
    property p_cfb_enc_no_t2;
        (ctrl_reg.cm == CM_CFB && ctrl_reg.op == OP_ENC) |-> !o_dma_trigger[2];
    endproperty
    a_cfb_enc_no_t2: assert property (p_cfb_enc_no_t2) else $error("line 2 in cfb enc"); // RULE1
    property p_t0_after_done;
        (cipher_done && seq_reg && ctrl_reg.dma_en && !soft_rst) |=> o_dma_trigger == 3'b001;
    endproperty
    a_t0_after_done: assert property (p_t0_after_done) else $error("line 0 not raised"); // RULE3
    property p_drop;
        hit |=> o_dma_trigger == 3'b000;
    endproperty
    a_drop: assert property (p_drop) else $error("request not dropped"); // RULE28
    property p_advance;
        (in_t && last_hit) |=> phase_reg != $past(phase_reg);
    endproperty
    a_advance: assert property (p_advance) else $error("no advance at 16 bytes"); // RULE5
    property p_blk_dec;
        (cipher_done && seq_reg && !blk_wr && blk_reg != 8'h00)
            |=> blk_reg == $past(blk_reg) - 8'h01;
    endproperty
    a_blk_dec: assert property (p_blk_dec) else $error("block count not decremented"); // RULE27
    property p_key_restore;
        start_ciph |=> rkey_reg == key_shadow_reg;
    endproperty
    a_key_restore: assert property (p_key_restore) else $error("key not restored"); // RULE7
    property p_soft_clear;
        soft_rst |=> state_reg == 128'h0 && phase_reg == PH_IDLE;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("state not cleared"); // RULE20
    property p_xin_no_start;
        (cnt_en && acc_tgt == TG_XIN && !seq_start) |=> phase_reg != PH_BUSY;
    endproperty
    a_xin_no_start: assert property (p_xin_no_start) else $error("xor input started"); // RULE19
    property p_seq_start;
        (seq_start && phase_reg == PH_IDLE && !soft_rst) |=> seq_reg;
    endproperty
    a_seq_start: assert property (p_seq_start) else $error("sequence not started"); // RULE9
    property p_key_flag;
        (ctrl_wr && i_av.writedata[`CTRL_KEY_WR]) |=> key_written_reg;
    endproperty
    a_key_flag: assert property (p_key_flag) else $error("key flag not set"); // RULE25

    c_cfb_dec_t2: cover property (ctrl_reg.cm == CM_CFB && o_dma_trigger[2]);
    c_ecb_done: cover property (ctrl_reg.cm == CM_ECB && seq_reg ##1 !seq_reg);
    c_cbc_dec_t2: cover property (ctrl_reg.cm == CM_CBC && o_dma_trigger[2]);

endmodule // aes_cipher_mode_dma_sequencer

// ### testbench/dma_model.sv
`timescale 1ns/1ps
`include "aes_seq_regs.svh"
module dma_model (
    input  wire logic            i_clk,
    input  wire logic [15:0]     i_readdata,
    input  wire logic            i_waitrequest,
    input  wire logic [2:0]      i_trigger,
    output aes_seq_pkg::av_req_t o_av
);
    import aes_seq_pkg::*;

    logic [2:0]  tgt[3];
    logic        is_rd[3];
    logic        byte_mode = 1'b0;
    logic        lane      = 1'b0;
    logic [15:0] cur       = 16'h0000;
    logic [15:0] rbuf      = 16'h0000;
    logic [15:0] src[$];
    logic [15:0] dst[$];
    int          lines[$];
    int          late_drops = 0;

    initial o_av = '0;

    // one access, held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic [2:0] a, input logic rd, input logic [15:0] d,
                        input logic [1:0] be, output logic [15:0] q);
        @(posedge i_clk);
        o_av <= '{a, rd, !rd, d, be};
        do
            @(posedge i_clk);
        while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_av.read  <= 1'b0;
        o_av.write <= 1'b0;
    endtask

    // level triggers, fixed priority, line 0 first
    task automatic serve(input int n);
        int          k;
        int          idle;
        int          i;
        logic [15:0] q;
        logic [1:0]  be;
        k = 0;
        idle = 0;
        while (k < n && idle < 200)
        begin
            @(negedge i_clk);
            if (i_trigger === 3'b000)
                idle++;
            else
            begin
                i = i_trigger[0] ? 0 : (i_trigger[1] ? 1 : 2);
                be = byte_mode ? (lane ? 2'b10 : 2'b01) : 2'b11;
                if (!is_rd[i] && !lane)
                    cur = src.pop_front();
                xfer(tgt[i], is_rd[i], cur, be, q);
                if (is_rd[i] && !byte_mode)
                    dst.push_back(q);
                else if (is_rd[i] && !lane)
                    rbuf = q;
                else if (is_rd[i])
                    dst.push_back({q[15:8], rbuf[7:0]});
                lane = byte_mode ? !lane : 1'b0;
                lines.push_back(i);
                k++;
                idle = 0;
                @(negedge i_clk);
                if (i_trigger[i] !== 1'b0)
                    late_drops++;
            end
        end
    endtask
endmodule // dma_model

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "aes_seq_regs.svh"
module tb;
    import aes_seq_pkg::*;

    logic        clk   = 1'b0;
    logic        rst_b = 1'b0;
    av_req_t     av;
    logic [15:0] rdata;
    logic        wreq;
    logic [2:0]  trig;
    logic        busy;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [15:0] pt[8];
    logic [15:0] ref_ct[$];
    logic [15:0] ct[$];
    logic [15:0] q;
    logic        diff;

    always #2 clk = ~clk;

    aes_cipher_mode_dma_sequencer dut_u (
        .i_clk        (clk),
        .i_rst_b      (rst_b),
        .i_av         (av),
        .o_readdata   (rdata),
        .o_waitrequest(wreq),
        .o_dma_trigger(trig),
        .o_busy       (busy)
    );

    dma_model dma_u (
        .i_clk        (clk),
        .i_readdata   (rdata),
        .i_waitrequest(wreq),
        .i_trigger    (trig),
        .o_av         (av)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        logic [15:0] x;
        dma_u.xfer(a, 1'b0, d, 2'b11, x);
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] x);
        dma_u.xfer(a, 1'b1, 16'h0000, 2'b11, x);
    endtask

    task automatic start(input logic [15:0] c);
        wr(`REG_CTRL, 16'h0080);
        wr(`REG_CTRL, c);
    endtask

    task automatic run(input logic [2:0] t0, t1, t2, input logic [2:0] rdm,
                       input int nblk, input int nx);
        dma_u.tgt = '{t0, t1, t2};
        for (int i = 0; i < 3; i++)
            dma_u.is_rd[i] = rdm[i];
        dma_u.lines.delete();
        dma_u.dst.delete();
        wr(`REG_BLOCK_COUNT, 16'(nblk));
        dma_u.serve(nx);
    endtask

    // each digit of pat is one quantity moved on that line
    task automatic expect_lines(input string pat, input int per);
        check(16'(dma_u.lines.size()), 16'(pat.len() * per));
        foreach (dma_u.lines[k])
            check(16'(dma_u.lines[k]), 16'(pat[k / per] - 8'h30));
        check(16'(dma_u.late_drops), 16'h0000);
        repeat (20)
        begin
            @(negedge clk);
            check(16'(trig), 16'h0000);
        end
    endtask

    task automatic t_reset();
        rd(`REG_STATUS, q);
        check(q, 16'h0000);
        rd(`REG_CTRL, q);
        check(q, 16'h0000);
        rd(`REG_KEY_IN, q);
        check(q, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_fields();
        for (int i = 0; i < 16; i++)
        begin
            wr(`REG_CTRL, 16'(i));
            rd(`REG_CTRL, q);
            check(q, 16'(i));
            wr(`REG_BLOCK_COUNT, 16'h0002);
            repeat (6)
            begin
                @(negedge clk);
                check(16'(trig), 16'h0000);
            end
        end
        wr(`REG_CTRL, 16'h0080);
        $display("test fields done");
    endtask

    task automatic t_ecb();
        start(16'h0010);
        for (int j = 0; j < 8; j++)
            wr(`REG_KEY_IN, 16'hc0de ^ 16'(j));
        for (int j = 0; j < 16; j++)
            dma_u.src.push_back(pt[j % 8]);
        run(`REG_DATA_OUT, `REG_DATA_IN, `REG_DATA_IN, 3'b001, 2, 32);
        expect_lines("1010", 8);
        for (int j = 0; j < 8; j++)
            check(dma_u.dst[j + 8], dma_u.dst[j]);
        ref_ct = dma_u.dst;
        $display("test ecb done");
    endtask

    task automatic t_ecb_byte();
        start(16'h0113);
        dma_u.byte_mode = 1'b1;
        for (int j = 0; j < 8; j++)
            dma_u.src.push_back(pt[j]);
        run(`REG_DATA_OUT, `REG_DATA_IN, `REG_DATA_IN, 3'b001, 1, 32);
        dma_u.byte_mode = 1'b0;
        expect_lines("10", 16);
        for (int j = 0; j < 8; j++)
            check(dma_u.dst[j], ref_ct[j]);
        $display("test ecb bytes done");
    endtask

    task automatic t_cbc();
        start(16'h0014);
        repeat (16)
            wr(`REG_XOR_IN, 16'h5a3c);
        @(negedge clk);
        check(16'(busy), 16'h0000);
        for (int j = 0; j < 16; j++)
            dma_u.src.push_back(pt[j % 8]);
        run(`REG_DATA_OUT, `REG_XOR_DATA_IN, `REG_DATA_IN, 3'b001, 2, 32);
        expect_lines("1010", 8);
        diff = 1'b0;
        for (int j = 0; j < 8; j++)
        begin
            check(dma_u.dst[j], ref_ct[j]);
            diff = diff | (dma_u.dst[j + 8] !== dma_u.dst[j]);
        end
        check(16'(diff), 16'h0001);
        $display("test cbc done");
    endtask

    task automatic t_cfb();
        start(16'h001c);
        for (int j = 0; j < 8; j++)
            wr(`REG_XOR_IN, 16'h3c00 + 16'(j));
        for (int j = 0; j < 16; j++)
            dma_u.src.push_back(pt[j % 8]);
        run(`REG_XOR_IN, `REG_DATA_OUT, `REG_DATA_IN, 3'b010, 2, 32);
        expect_lines("0101", 8);
        ct = dma_u.dst;
        start(16'h011d);
        rd(`REG_STATUS, q);
        check(16'(q[4]), 16'h0001);
        for (int j = 0; j < 8; j++)
            wr(`REG_XOR_IN, 16'h3c00 + 16'(j));
        for (int j = 0; j < 24; j++)
            dma_u.src.push_back(ct[(j < 16) ? (j % 8) : (j - 8)]);
        run(`REG_XOR_IN, `REG_DATA_OUT, `REG_DATA_IN, 3'b010, 2, 40);
        expect_lines("01201", 8);
        for (int j = 0; j < 16; j++)
            check(dma_u.dst[j], pt[j % 8]);
        $display("test cfb done");
    endtask

    initial
    begin
        for (int j = 0; j < 8; j++)
            pt[j] = 16'h1357 + 16'(j) * 16'h0f0f;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_fields();
        t_ecb();
        t_ecb_byte();
        t_cbc();
        t_cfb();
        stop_test();
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule // tb
